// ---- src/swtg_pkg.sv ----
// Constants shared by the sweep trigger and gate control block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package swtg_pkg;
  // Clock and derived converter clock
  localparam int unsigned PCLK_HZ      = 50_000_000;
  localparam int unsigned CONV_CLK_HZ  = 1_000_000;
  localparam int unsigned CONV_DIV     = PCLK_HZ / CONV_CLK_HZ;
  localparam int unsigned CONV_HALF    = CONV_DIV / 2;
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned DAC_W        = 8;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] GATE_DLY_OFF  = 8'h04;
  localparam logic [7:0] GATE_LEN_OFF  = 8'h08;
  localparam logic [7:0] LEVEL_OFF     = 8'h0c;
  localparam logic [7:0] STATUS_OFF    = 8'h10;
  localparam logic [7:0] SCAN_CMD_OFF  = 8'h14;
  // Control field positions
  localparam int unsigned CTRL_SEL_LO  = 0;
  localparam int unsigned CTRL_SEL_HI  = 1;
  localparam int unsigned CTRL_SINGLE  = 2;
  localparam int unsigned CTRL_GATE_EN = 3;
  localparam int unsigned CTRL_EDGE    = 4;
  localparam int unsigned CTRL_NEG     = 5;
  localparam int unsigned CTRL_W       = 6;
  // Scan command bits
  localparam int unsigned CMD_CLEAR    = 0;
  localparam int unsigned CMD_ARM      = 1;
  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [CNT_W-1:0]  DLY_RST  = 24'h000000;
  localparam logic [CNT_W-1:0]  LEN_RST  = 24'h000000;
  localparam logic [DAC_W-1:0]  DAC_RST  = 8'h00;
  // Level DAC strobe sequence length in pclk cycles
  localparam logic [1:0] DAC_SEQ_LEN     = 2'h3;
  // Trigger source codes {hi, lo}
  typedef enum logic [1:0] {
    SRC_FREE  = 2'b00,
    SRC_VIDEO = 2'b01,
    SRC_LINE  = 2'b11,
    SRC_EXT   = 2'b10
  } swtg_src_t;
  // Gate sequencer states, Gray coded
  typedef enum logic [1:0] {
    G_IDLE  = 2'b00,
    G_DELAY = 2'b01,
    G_LEN   = 2'b11,
    G_REL   = 2'b10
  } swtg_gate_t;
endpackage : swtg_pkg

// ---- src/swtg_interval.sv ----
// One down-counting interval timer channel.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/1ps
module swtg_interval (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      tick,
  input  wire logic                      start,
  input  wire logic [swtg_pkg::CNT_W-1:0] length,
  output logic                           busy,
  output logic                           done
);
  logic [swtg_pkg::CNT_W-1:0] count_reg;

  // Load on start, count ticks, pulse done at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= length;
        busy      <= (length != '0);
        done      <= (length == '0);   // Zero length ends at once
      end else if (busy && tick) begin
        if (count_reg == {{(swtg_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : swtg_interval

// ---- src/swtg_core.sv ----
// Sweep trigger selection, scan latch and gated-video timing with APB registers.
// Assumes 50 MHz pclk, asynchronous trigger pins, and a strobe-select block
// driving the timer strobe.
//
// Functional notes
// - One of four trigger sources picked by two select lines.
// - Select codes lo,hi: LL free, HL video, HH line, LH external.
// - Selected trigger sets scan latch output high to start sweep.
// - Free run and single triggering synced to converter clock; free trigger from it.
// - Gate trigger has level mode and edge mode, chosen by configuration.
// - Edge mode uses rising or falling gate edge, selectable.
// - Timer channel zero times delay, channel one times length.
// - Delay and length programmable; last loaded values are used.
// - Gate timing triggered from external gate trigger input.
// - Level DAC loaded with select and write strobes; one step per volt.
`timescale 1ns/1ps
module swtg_core (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Trigger sources and gate input, asynchronous
  input  wire logic                      video_trig_in,
  input  wire logic                      line_sync_in,
  input  wire logic                      ext_trig_in,
  input  wire logic                      gate_trig_in,
  input  wire logic                      gate_timer_strobe_n,
  // Outputs
  output logic                           trig_select_bit_lo,
  output logic                           trig_select_bit_hi,
  output logic                           scan_start_latch,
  output logic                           converter_clock_out,
  output logic                           video_gate,
  output logic [swtg_pkg::DAC_W-1:0]     level_dac_code,
  output logic                           level_dac_load_n,
  output logic                           write_strobe_n
);
  // Register state
  logic [swtg_pkg::CTRL_W-1:0] ctrl_reg;
  logic [swtg_pkg::CNT_W-1:0]  dly_reg;
  logic [swtg_pkg::CNT_W-1:0]  len_reg;
  logic [swtg_pkg::CNT_W-1:0]  dly_act_reg;
  logic [swtg_pkg::CNT_W-1:0]  len_act_reg;
  logic                        timer_en_reg;
  logic                        armed_reg;
  logic                        pending_reg;
  logic [1:0]                  dac_seq_reg;
  // Synchronisers
  logic [1:0]                  video_s, line_s, ext_s, gate_s, tstb_s;
  logic                        gate_d, tstb_d;
  // Divider
  logic [5:0]                  div_reg;
  logic                        conv_tick;
  // Trigger path
  logic                        src_level, src_prev, trig_event;
  logic                        single_mode, sync_mode;
  // Gate path
  swtg_pkg::swtg_gate_t        gstate_reg;
  logic                        gate_active, gate_qual;
  logic                        start0, start1, busy0, busy1, done0, done1;
  // Bus decode
  logic                        setup, access, wr_en, addr_ok;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_en   = access && pwrite;
  assign pready  = 1'b1;   // Zero wait states

  // Decode of mapped offsets
  always_comb begin
    case (paddr)
      swtg_pkg::CTRL_OFF,
      swtg_pkg::GATE_DLY_OFF,
      swtg_pkg::GATE_LEN_OFF,
      swtg_pkg::LEVEL_OFF,
      swtg_pkg::STATUS_OFF,
      swtg_pkg::SCAN_CMD_OFF: addr_ok = 1'b1;
      default:                addr_ok = 1'b0;
    endcase
  end

  assign pslverr = access && !addr_ok;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_s <= 2'b00;
      line_s  <= 2'b00;
      ext_s   <= 2'b00;
      gate_s  <= 2'b00;
      tstb_s  <= 2'b11;
    end else begin
      video_s <= {video_s[0], video_trig_in};
      line_s  <= {line_s[0], line_sync_in};
      ext_s   <= {ext_s[0], ext_trig_in};
      gate_s  <= {gate_s[0], gate_trig_in};
      tstb_s  <= {tstb_s[0], gate_timer_strobe_n};
    end
  end

  // Previous synchronised values for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_d <= 1'b0;
      tstb_d <= 1'b1;
    end else begin
      gate_d <= gate_s[1];
      tstb_d <= tstb_s[1];
    end
  end

  // Converter clock divider: 1 MHz square wave and tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg             <= 6'h00;
      converter_clock_out <= 1'b0;
    end else begin
      if (div_reg == 6'(swtg_pkg::CONV_DIV - 1)) begin
        div_reg <= 6'h00;
      end else begin
        div_reg <= div_reg + 6'h01;
      end
      converter_clock_out <= (div_reg < 6'(swtg_pkg::CONV_HALF));
    end
  end

  // Tick marks the converter clock rising edge
  assign conv_tick = (div_reg == 6'h00);

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= swtg_pkg::CTRL_RST;
    end else if (wr_en && paddr == swtg_pkg::CTRL_OFF) begin
      ctrl_reg <= pwdata[swtg_pkg::CTRL_W-1:0];
    end
  end

  // select lines follow the control field
  assign trig_select_bit_lo = ctrl_reg[swtg_pkg::CTRL_SEL_LO];
  assign trig_select_bit_hi = ctrl_reg[swtg_pkg::CTRL_SEL_HI];
  assign single_mode        = ctrl_reg[swtg_pkg::CTRL_SINGLE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_reg <= swtg_pkg::DLY_RST;
      len_reg <= swtg_pkg::LEN_RST;
    end else if (wr_en) begin
      if (paddr == swtg_pkg::GATE_DLY_OFF) begin
        dly_reg <= pwdata[swtg_pkg::CNT_W-1:0];
      end
      if (paddr == swtg_pkg::GATE_LEN_OFF) begin
        len_reg <= pwdata[swtg_pkg::CNT_W-1:0];
      end
    end
  end

  // timer strobe loads values and enables the timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_act_reg  <= swtg_pkg::DLY_RST;
      len_act_reg  <= swtg_pkg::LEN_RST;
      timer_en_reg <= 1'b0;
    end else if (tstb_d && !tstb_s[1]) begin
      dly_act_reg  <= dly_reg;
      len_act_reg  <= len_reg;
      timer_en_reg <= 1'b1;
    end
  end

  always_comb begin
    case (swtg_pkg::swtg_src_t'({trig_select_bit_hi, trig_select_bit_lo}))
      // free run taken from converter clock
      swtg_pkg::SRC_FREE:  src_level = converter_clock_out;
      swtg_pkg::SRC_VIDEO: src_level = video_s[1];
      swtg_pkg::SRC_LINE:  src_level = line_s[1];
      swtg_pkg::SRC_EXT:   src_level = ext_s[1];
      default:             src_level = 1'b0;
    endcase
  end

  // Rising edge of the chosen source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign trig_event = src_level && !src_prev;
  assign sync_mode  = single_mode ||
                      ({trig_select_bit_hi, trig_select_bit_lo} == swtg_pkg::SRC_FREE);

  // Single mode arms once per software request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (wr_en && paddr == swtg_pkg::SCAN_CMD_OFF
                 && pwdata[swtg_pkg::CMD_ARM]) begin
      armed_reg <= 1'b1;
    end else if (scan_start_latch) begin
      armed_reg <= 1'b0;
    end
  end

  // pending trigger waits for converter clock tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (trig_event && sync_mode) begin
      pending_reg <= 1'b1;   // Set wins over the tick clear
    end else if (conv_tick) begin
      pending_reg <= 1'b0;
    end
  end

  // scan latch set by trigger, cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_start_latch <= 1'b0;
    end else if ((single_mode ? armed_reg : 1'b1) &&
                 (sync_mode ? (pending_reg && conv_tick) : trig_event)) begin
      scan_start_latch <= 1'b1;
    end else if (wr_en && paddr == swtg_pkg::SCAN_CMD_OFF
                 && pwdata[swtg_pkg::CMD_CLEAR]) begin
      scan_start_latch <= 1'b0;
    end
  end

  // gate trigger from external gate pin; level or edge mode
  always_comb begin
    if (ctrl_reg[swtg_pkg::CTRL_EDGE]) begin
      gate_qual = ctrl_reg[swtg_pkg::CTRL_NEG] ? (gate_d && !gate_s[1])
                                                : (!gate_d && gate_s[1]);
    end else begin
      gate_qual   = gate_s[1] ^ ctrl_reg[swtg_pkg::CTRL_NEG];
    end
    gate_active = ctrl_reg[swtg_pkg::CTRL_GATE_EN] && timer_en_reg && gate_qual;
  end

  // gate sequencer: delay, length, then wait for next trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gstate_reg <= swtg_pkg::G_IDLE;
    end else if (!ctrl_reg[swtg_pkg::CTRL_GATE_EN] || !timer_en_reg) begin
      gstate_reg <= swtg_pkg::G_IDLE;
    end else begin
      case (gstate_reg)
        swtg_pkg::G_IDLE:  if (gate_active) gstate_reg <= swtg_pkg::G_DELAY;
        swtg_pkg::G_DELAY: if (done0) gstate_reg <= swtg_pkg::G_LEN;
        swtg_pkg::G_LEN:   if (done1) gstate_reg <= swtg_pkg::G_REL;
        swtg_pkg::G_REL: begin
          // Level mode must see the level drop before retrigger
          if (ctrl_reg[swtg_pkg::CTRL_EDGE] || !gate_qual) begin
            gstate_reg <= swtg_pkg::G_IDLE;
          end
        end
        default:           gstate_reg <= swtg_pkg::G_IDLE;
      endcase
    end
  end

  // channel starts: zero on trigger, one when delay ends
  assign start0 = (gstate_reg == swtg_pkg::G_IDLE) && gate_active;
  assign start1 = (gstate_reg == swtg_pkg::G_DELAY) && done0;

  // channel zero times the gate delay
  swtg_interval u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (conv_tick),
    .start   (start0),
    .length  (dly_act_reg),
    .busy    (busy0),
    .done    (done0)
  );

  // channel one times the gate length
  swtg_interval u_length (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (conv_tick),
    .start   (start1),
    .length  (len_act_reg),
    .busy    (busy1),
    .done    (done1)
  );

  // video gate registered from length channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_gate <= 1'b0;
    end else begin
      video_gate <= busy1;
    end
  end

  // level DAC code, one code step per volt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_dac_code <= swtg_pkg::DAC_RST;
    end else if (wr_en && paddr == swtg_pkg::LEVEL_OFF) begin
      level_dac_code <= pwdata[swtg_pkg::DAC_W-1:0];
    end
  end

  // select strobe for three cycles, write strobe in the middle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_seq_reg      <= 2'h0;
      level_dac_load_n <= 1'b1;
      write_strobe_n   <= 1'b1;
    end else begin
      if (wr_en && paddr == swtg_pkg::LEVEL_OFF) begin
        dac_seq_reg <= swtg_pkg::DAC_SEQ_LEN;
      end else if (dac_seq_reg != 2'h0) begin
        dac_seq_reg <= dac_seq_reg - 2'h1;
      end
      level_dac_load_n <= !((wr_en && paddr == swtg_pkg::LEVEL_OFF) ||
                            (dac_seq_reg > 2'h1));
      write_strobe_n   <= !(dac_seq_reg == swtg_pkg::DAC_SEQ_LEN);
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (paddr)
        swtg_pkg::CTRL_OFF:     prdata <= {26'h0, ctrl_reg};
        swtg_pkg::GATE_DLY_OFF: prdata <= {8'h00, dly_reg};
        swtg_pkg::GATE_LEN_OFF: prdata <= {8'h00, len_reg};
        swtg_pkg::LEVEL_OFF:    prdata <= {24'h0, level_dac_code};
        swtg_pkg::STATUS_OFF:   prdata <= {20'h0, video_s[1], line_s[1], ext_s[1],
                                           gate_s[1], gstate_reg, busy1, busy0,
                                           timer_en_reg, armed_reg, pending_reg,
                                           scan_start_latch};
        default:                prdata <= 32'h00000000;
      endcase
    end
  end
endmodule : swtg_core

// ---- dv/swtg_core_sva.sv ----
// Checker for the sweep trigger and gate control block.
// Assumes it is bound to swtg_core and sees only its ports.
`timescale 1ns/1ps
module swtg_core_sva (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  input wire logic                        gate_timer_strobe_n,
  input wire logic                        trig_select_bit_lo,
  input wire logic                        trig_select_bit_hi,
  input wire logic                        scan_start_latch,
  input wire logic                        converter_clock_out,
  input wire logic                        video_gate,
  input wire logic [swtg_pkg::DAC_W-1:0]  level_dac_code,
  input wire logic                        level_dac_load_n,
  input wire logic                        write_strobe_n
);
  logic wr_acc;
  logic strobe_seen;
  // Completed write access
  assign wr_acc = psel && penable && pwrite && pready;
  // Remembers any timer strobe since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) strobe_seen <= 1'b0;
    else if (!gate_timer_strobe_n) strobe_seen <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sel_follow_a: assert property (
    wr_acc && paddr == swtg_pkg::CTRL_OFF |=> {trig_select_bit_hi, trig_select_bit_lo}
      == $past(pwdata[1:0])) else $error("select lines differ from control write");
  conv_high_a: assert property (
    $rose(converter_clock_out) |-> ##24 converter_clock_out ##1 !converter_clock_out)
    else $error("converter clock high phase wrong");
  conv_low_a: assert property (
    $fell(converter_clock_out) |-> ##24 !converter_clock_out ##1 converter_clock_out)
    else $error("converter clock low phase wrong");
  free_sync_a: assert property (
    $rose(scan_start_latch) && !trig_select_bit_lo && !trig_select_bit_hi
      |-> converter_clock_out) else $error("free run start off converter clock");
  latch_hold_a: assert property (
    scan_start_latch && !(wr_acc && paddr == swtg_pkg::SCAN_CMD_OFF && pwdata[0])
      |=> scan_start_latch) else $error("scan latch dropped without clear");
  dac_pulse_a: assert property (
    wr_acc && paddr == swtg_pkg::LEVEL_OFF |=> !level_dac_load_n [*3] ##1 level_dac_load_n)
    else $error("level load pulse wrong");
  dac_code_a: assert property (
    wr_acc && paddr == swtg_pkg::LEVEL_OFF |=> level_dac_code
      == $past(pwdata[swtg_pkg::DAC_W-1:0])) else $error("level code not last written");
  wstrobe_mid_a: assert property (
    $fell(write_strobe_n) |-> !level_dac_load_n && !$past(level_dac_load_n)
      ##1 write_strobe_n && !level_dac_load_n) else $error("write strobe outside load");
  gate_idle_a: assert property (
    !strobe_seen |-> !video_gate) else $error("gate active without timer strobe");
endmodule : swtg_core_sva

bind swtg_core swtg_core_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .gate_timer_strobe_n, .trig_select_bit_lo, .trig_select_bit_hi,
  .scan_start_latch, .converter_clock_out, .video_gate, .level_dac_code,
  .level_dac_load_n, .write_strobe_n);

// ---- dv/swtg_far_side.sv ----
// Model of trigger sources, gate pin and host strobe select.
// Assumes the bench calls its tasks; pins change after rising edges.
`timescale 1ns/1ps
module swtg_far_side (
  input wire logic pclk,
  output logic     video_trig_in,
  output logic     line_sync_in,
  output logic     ext_trig_in,
  output logic     gate_trig_in,
  output logic     gate_timer_strobe_n
);
  // Idle levels at time zero
  initial begin
    video_trig_in = 1'b0;
    line_sync_in = 1'b0;
    ext_trig_in = 1'b0;
    gate_trig_in = 1'b0;
    gate_timer_strobe_n = 1'b1;
  end
  task automatic pulse(input logic [1:0] src, input int wid);
    @(posedge pclk);
    case (src)
      swtg_pkg::SRC_VIDEO: video_trig_in <= 1'b1;
      swtg_pkg::SRC_LINE: line_sync_in <= 1'b1;
      swtg_pkg::SRC_EXT: ext_trig_in <= 1'b1;
      default: ;
    endcase
    repeat (wid) @(posedge pclk);
    video_trig_in <= 1'b0;
    line_sync_in <= 1'b0;
    ext_trig_in <= 1'b0;
  endtask : pulse
  task automatic set_gate(input logic v);
    @(posedge pclk);
    gate_trig_in <= v;
  endtask : set_gate
  task automatic strobe(input int wid);
    @(posedge pclk);
    gate_timer_strobe_n <= 1'b0;
    repeat (wid) @(posedge pclk);
    gate_timer_strobe_n <= 1'b1;
  endtask : strobe
endmodule : swtg_far_side

// ---- dv/test_sweep_trigger_gate_control.sv ----
// Self-checking bench for the sweep trigger and gate control block.
// Assumes swtg_core, its package, the far side model and the checker.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (a)); bad_count++; end end
module test_sweep_trigger_gate_control;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata;
  logic                        video_trig_in, line_sync_in, ext_trig_in, gate_trig_in;
  logic                        gate_timer_strobe_n, trig_select_bit_lo, trig_select_bit_hi;
  logic                        scan_start_latch, converter_clock_out, video_gate;
  logic                        level_dac_load_n, write_strobe_n;
  logic [swtg_pkg::DAC_W-1:0]  level_dac_code;
  logic [32:0]                 exp_q[$];
  int                          bad_count, samples_checked, t, d, l;
  logic [1:0]                  src, oth;
  logic [7:0]                  v;
  logic                        neg;
  swtg_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .video_trig_in, .line_sync_in, .ext_trig_in, .gate_trig_in,
    .gate_timer_strobe_n, .trig_select_bit_lo, .trig_select_bit_hi, .scan_start_latch,
    .converter_clock_out, .video_gate, .level_dac_code, .level_dac_load_n, .write_strobe_n);
  swtg_far_side i_far (.pclk, .video_trig_in, .line_sync_in, .ext_trig_in, .gate_trig_in,
    .gate_timer_strobe_n);
  // Clock
  always #10 pclk = ~pclk;
  // Read monitor pairs each access with the oldest expectation
  always @(posedge pclk) begin : mon
    logic [32:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      `CHK("apb read", e, {pslverr, prdata})
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // APB transfer; a read notes its expected error flag and data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt,
                     input logic err);
    int w;
    if (!wr) exp_q.push_back({err, dt});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? dt : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 50) begin
      bad_count++;
      stop_test();
    end
    @(negedge pclk);
  endtask : apb
  task automatic wait_latch(input int mx, input logic ex, input string nm);
    int n;
    n = 0;
    while (scan_start_latch !== 1'b1 && n < mx) begin
      @(negedge pclk);
      n++;
    end
    `CHK(nm, ex, scan_start_latch)
    if (ex && scan_start_latch !== 1'b1) stop_test();
  endtask : wait_latch
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(96536));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("load_n", 1'b1, level_dac_load_n)
    apb(0, swtg_pkg::CTRL_OFF, 32'h0, 0);
    apb(0, swtg_pkg::GATE_DLY_OFF, 32'h0, 0);
    apb(0, swtg_pkg::GATE_LEN_OFF, 32'h0, 0);
    apb(0, swtg_pkg::LEVEL_OFF, 32'h0, 0);
    apb(1, 8'h20, 32'h3f, 0);
    apb(0, 8'h20, 32'h0, 1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      src = (i == 0) ? 2'b00 : (i == 1) ? 2'b01 : (i == 2) ? 2'b11 : 2'b10;
      oth = (src == 2'b01) ? 2'b11 : (src == 2'b11) ? 2'b10 : 2'b01;
      apb(1, swtg_pkg::CTRL_OFF, {30'h0, src}, 0);
      `CHK("select", src, {trig_select_bit_hi, trig_select_bit_lo})
      apb(0, swtg_pkg::CTRL_OFF, {30'h0, src}, 0);
      apb(1, swtg_pkg::SCAN_CMD_OFF, 32'h1, 0);
      if (src != 2'b00) begin
        i_far.pulse(oth, 1 + i);
        wait_latch(60, 1'b0, "other source");
        i_far.pulse(src, 1 + i);
      end
      wait_latch(60, 1'b1, "latch set");
    end
    apb(1, swtg_pkg::CTRL_OFF, 32'h1 << swtg_pkg::CTRL_SINGLE, 0);
    apb(1, swtg_pkg::SCAN_CMD_OFF, 32'h1, 0);
    wait_latch(120, 1'b0, "single unarmed");
    apb(1, swtg_pkg::SCAN_CMD_OFF, 32'h2, 0);
    wait_latch(60, 1'b1, "single armed");
    apb(1, swtg_pkg::SCAN_CMD_OFF, 32'h1, 0);
    wait_latch(120, 1'b0, "single once");
    $display("test trigger done");
    v = 8'($urandom % 255);
    apb(1, swtg_pkg::LEVEL_OFF, {24'h0, v}, 0);
    repeat (4) @(negedge pclk);
    apb(1, swtg_pkg::LEVEL_OFF, {24'h0, v + 8'h1}, 0);
    `CHK("dac step", v + 8'h1, level_dac_code)
    `CHK("load pulse", 2'b01, {level_dac_load_n, write_strobe_n})
    @(negedge pclk);
    `CHK("write strobe", 2'b00, {level_dac_load_n, write_strobe_n})
    repeat (3) @(negedge pclk);
    apb(0, swtg_pkg::LEVEL_OFF, {24'h0, v + 8'h1}, 0);
    $display("test level done");
    apb(1, swtg_pkg::GATE_DLY_OFF, 32'h1, 0);
    apb(1, swtg_pkg::GATE_LEN_OFF, 32'h1, 0);
    apb(1, swtg_pkg::CTRL_OFF, 32'h18, 0);
    i_far.set_gate(1'b1);
    t = 0;
    repeat (250) begin
      @(negedge pclk);
      if (video_gate === 1'b1) t++;
    end
    `CHK("gate without strobe", 0, t)
    i_far.set_gate(1'b0);
    for (int m = 0; m < 4; m++) begin
      neg = m[0];
      d = 1 + $urandom % 3;
      l = 1 + $urandom % 3;
      // Gate off while the pin settles at its idle level
      apb(1, swtg_pkg::CTRL_OFF, {26'h0, neg, !m[1], 4'h0}, 0);
      i_far.set_gate(neg);
      apb(1, swtg_pkg::GATE_DLY_OFF, d, 0);
      apb(1, swtg_pkg::GATE_LEN_OFF, l, 0);
      apb(1, swtg_pkg::CTRL_OFF, {26'h0, neg, !m[1], 4'h8}, 0);
      i_far.strobe(2 + 3 * m);
      repeat (8) @(negedge pclk);
      i_far.set_gate(!neg);
      t = 0;
      while (video_gate !== 1'b1 && t < 300) begin
        @(negedge pclk);
        t++;
      end
      `CHK("delay", 1'b1, t >= d * 50 - 50 && t <= d * 50 + 60)
      if (t >= 300) stop_test();
      t = 0;
      while (video_gate === 1'b1 && t < 300) begin
        @(negedge pclk);
        t++;
      end
      `CHK("length", 1'b1, t >= l * 50 - 2 && t <= l * 50 + 2)
      if (t >= 300) stop_test();
      i_far.set_gate(neg);
      repeat (8) @(negedge pclk);
    end
    $display("test gate done");
    stop_test();
  end
endmodule : test_sweep_trigger_gate_control
